// File: lbsp_pkg.sv
package lbsp_pkg;

  // Array shape
  localparam int ADDR_W = 21;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int HI_W = ADDR_W - BURST_W;
  localparam int DEPTH = 2097152;

  // Reset values
  localparam logic [DATA_W-1:0] RD_RST = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [HI_W-1:0] HI_RST = 19'h00000;
  localparam logic [LANES-1:0] LANE_RST = 2'h0;
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;

  // Burst order select levels
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } lbsp_op_t;

endpackage

// File: lbsp_burst_ctr.sv
`timescale 1ns/10ps
module lbsp_burst_ctr import lbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic advance,
  input wire logic order_sel,
  input wire logic [BURST_W-1:0] seed,
  output logic [BURST_W-1:0] low_addr
);

  logic [BURST_W-1:0] seed_q;
  logic [BURST_W-1:0] cnt_q;
  logic [BURST_W-1:0] cnt_nx;
  logic [BURST_W-1:0] step_low;

  assign cnt_nx = cnt_q + CNT_STEP;
  // Interleaved XORs the seed, linear adds modulo four
  assign step_low = (order_sel == ORDER_INTERLEAVED) ? (seed_q ^ cnt_nx)
                                                     : (seed_q + cnt_nx);
  assign low_addr = load ? seed : step_low;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seed_q <= CNT_RST;
      cnt_q <= CNT_RST;
    end else if (load) begin
      seed_q <= seed;
      cnt_q <= CNT_RST;
    end else if (advance) begin
      cnt_q <= cnt_nx;
    end
  end

endmodule // lbsp_burst_ctr

// File: lbsp_store.sv
`timescale 1ns/10ps
module lbsp_store import lbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [LANES-1:0] wr_lane,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // One array per lane, so each array has a single writer
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [0:DEPTH-1];

      assign rd_data[g*LANE_W +: LANE_W] = lane_mem[rd_addr];

      always_ff @(posedge clk_sys) begin
        if (wr_en && wr_lane[g]) begin
          lane_mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
        end
      end
    end
  endgenerate

endmodule // lbsp_store

// File: lbsp_port.sv
// Functional notes
// - Write data arrives and is stored one edge after the write command.
// - On a load, read_not_write high starts a read, low a write.
// - Each active-low byte enable gates its own lane; all low writes 18 bits.
// - Byte enables sampled with write commands and burst write continuations.
// - Any of three chip selects deselecting forces data pins high impedance.
// - Advance high ignores address, selects, direction; counter steps by order.
// - Advance low with selection loads a new external address.
// - clock_hold_n high freezes every operation including burst progress.
// - Address sampled only when all selects active and a load is requested.
// - Chip selects sampled only on load edges, ignored while advancing.
// - Data pins driven only when enabled and output enable active.
// - Output enable acts asynchronously; inactive means pins undriven.
// - No output enable toggle needed; drivers turn off for writes.
// - burst_order_sel high means interleaved order, low means linear.
// - sleep_request high enters low power, retains data, blocks operations.
// - All inputs clocked except output enable, order and sleep.
// - Reads answer one cycle later; reads and writes mix with no gap.
// - Write command and address are registered on a rising edge.
// - Linear steps low bits by one; interleaved XORs with 01, 10, 11.
// - Two-bit counter wraps to the start every fourth burst cycle.
// - Continuations repeat the loaded operation type and advance the address.
// - Held cycle writes nothing; bus stays driven on read, released on write.
`timescale 1ns/10ps
module lbsp_port import lbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clock_hold_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] byte_write_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic out_en_n,
  input wire logic burst_order_sel,
  input wire logic sleep_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and sleep synchroniser

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic sleep_meta_q;
  logic sleep_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      sleep_meta_q <= sleep_request;
      sleep_q <= sleep_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  lbsp_op_t op_q;
  lbsp_op_t op_d;
  logic run;
  logic is_load;
  logic is_adv;
  logic selected;
  logic load_sel;
  logic acc_read;
  logic acc_write;
  logic lane_any;

  // Sleep blocks new work while stored data is kept
  assign run = !clock_hold_n && !sleep_q;
  assign is_load = run && !advance_or_load;
  assign is_adv = run && advance_or_load;
  assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign load_sel = is_load && selected;
  assign lane_any = !(&byte_write_n);

  always_comb begin
    op_d = op_q;
    if (is_load) begin
      if (!selected) begin
        op_d = OP_IDLE;
      end else if (read_not_write) begin
        op_d = OP_READ;
      end else begin
        op_d = OP_WRITE;
      end
    end
  end

  // Continuation keeps op_q, so its type repeats
  assign acc_read = run && (op_d == OP_READ);
  assign acc_write = run && (op_d == OP_WRITE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= OP_IDLE;
    end else begin
      op_q <= op_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst address

  logic [HI_W-1:0] hi_q;
  logic [BURST_W-1:0] low_addr;
  logic [ADDR_W-1:0] eff_addr;

  lbsp_burst_ctr u_ctr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(load_sel),
    .advance(is_adv),
    .order_sel(burst_order_sel),
    .seed(addr[BURST_W-1:0]),
    .low_addr(low_addr)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= HI_RST;
    end else if (load_sel) begin
      hi_q <= addr[ADDR_W-1:BURST_W];
    end
  end

  assign eff_addr = load_sel ? addr : {hi_q, low_addr};

  ////////////////////////////////////////////////////////////////////////////
  // Late write pipeline

  logic wr_pend_q;
  logic [LANES-1:0] wr_be_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic mem_we;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_be_q <= LANE_RST;
      wr_addr_q <= ADDR_RST;
    end else if (run) begin
      wr_pend_q <= acc_write && lane_any;
      wr_be_q <= ~byte_write_n;
      wr_addr_q <= eff_addr;
    end
  end

  // Data is taken on the next unheld edge after the command
  assign mem_we = run && wr_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Array and flow-through read

  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] rd_merge;
  logic [DATA_W-1:0] rd_q;
  logic drive_q;
  logic hit;

  lbsp_store u_store (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_lane(wr_be_q),
    .wr_addr(wr_addr_q),
    .wr_data(dq_in),
    .rd_addr(eff_addr),
    .rd_data(mem_rd)
  );

  // A read right after a write to the same word sees the new lanes
  assign hit = mem_we && (wr_addr_q == eff_addr);

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_merge
      assign rd_merge[g*LANE_W +: LANE_W] = (hit && wr_be_q[g])
        ? dq_in[g*LANE_W +: LANE_W] : mem_rd[g*LANE_W +: LANE_W];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= RD_RST;
      drive_q <= 1'b0;
    end else if (run) begin
      drive_q <= acc_read;
      if (acc_read) begin
        rd_q <= rd_merge;
      end
    end
  end

  assign dq_out = rd_q;
  // Output enable and sleep gate the drivers without the clock
  assign dq_oe = drive_q && !out_en_n && !sleep_request;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  late_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_write && lane_any |=> wr_pend_q)
    else $error("write command not followed by pending write");

  rw_type_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_sel |=> op_q == ($past(read_not_write) ? OP_READ : OP_WRITE))
    else $error("load did not start the requested operation");

  lane_sample_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_write |=> wr_be_q == ~$past(byte_write_n))
    else $error("byte enables not sampled with write");

  deselect_hiz_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_load && !selected |=> !dq_oe)
    else $error("data driven after deselect");

  hold_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clock_hold_n |=> $stable(op_q) && $stable(rd_q) && $stable(hi_q))
    else $error("state changed during clock hold");

  oe_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_en_n || sleep_request |-> !dq_oe)
    else $error("data driven with output enable inactive");

  hold_nowrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clock_hold_n |-> !mem_we)
    else $error("write during clock hold");

  cont_type_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_adv |=> $stable(op_q))
    else $error("continuation changed operation type");

  write_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && (&byte_write_n) |=> !wr_pend_q)
    else $error("aborted write left pending");

  read_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_read && !out_en_n ##1 !out_en_n && !sleep_request |-> dq_oe)
    else $error("read data not driven one cycle later");

  burst_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    load_sel ##1 is_adv[*4] |-> low_addr == $past(addr[BURST_W-1:0], 4))
    else $error("burst did not wrap to start");

  rw_turn_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    acc_read ##1 acc_write ##1 acc_read);

  burst_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    load_sel && read_not_write ##1 (is_adv && op_q == OP_READ)[*3]);

  held_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    acc_read ##1 clock_hold_n[*3] ##1 !clock_hold_n);

  bypass_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hit && acc_read);

endmodule // lbsp_port

// File: lbsp_master.sv
`timescale 1ns/10ps
module lbsp_master import lbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic clock_hold_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] wq[$];
  logic held = 1'b0;
  logic wr_burst = 1'b0;
  logic due = 1'b0;
  initial dq_in = 18'h15a5a;
  ////////////////////////////////////////////////////////////////////////////
  // Note which unheld edges took a write command or write continuation
  always @(posedge clk_sys) begin
    held = clock_hold_n;
    if (!clock_hold_n) begin
      if (!advance_or_load) begin
        wr_burst = !chip_select_a_n && chip_select_b && !chip_select_c_n &&
          !read_not_write;
      end
      due = wr_burst;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Data follows its command by one cycle; a released bus keeps toggling
  always @(negedge clk_sys) begin
    if (!held) begin
      if (due && wq.size() > 0) dq_in <= wq.pop_front();
      else dq_in <= ~dq_in;
    end
  end
endmodule // lbsp_master

// File: late_write_burst_sram_port_test.sv
`timescale 1ns/10ps
module late_write_burst_sram_port_test import lbsp_pkg::*;;
  logic clk_sys = 1'b0;
  logic arst_n, clock_hold_n, chip_select_a_n, chip_select_b, chip_select_c_n;
  logic advance_or_load, read_not_write, out_en_n, burst_order_sel;
  logic sleep_request, dq_oe;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] byte_write_n;
  logic [DATA_W-1:0] dq_in, dq_out;
  int err_total = 0;
  int total_checks = 0;
  logic [31:0] lfsr_q = 32'hb208;
  logic [31:0] r;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] blk [2];
  logic [ADDR_W-1:0] cur_m, pa;
  logic [1:0] base_m, k_m, pbw;
  logic [DATA_W-1:0] pd, e_dat;
  logic wr_m = 1'b0, live_m = 1'b0, pw = 1'b0, chk = 1'b0, e_oe = 1'b0;

  lbsp_port lbsp_port_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .clock_hold_n(clock_hold_n), .chip_select_a_n(chip_select_a_n),
    .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
    .advance_or_load(advance_or_load), .read_not_write(read_not_write),
    .addr(addr), .byte_write_n(byte_write_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .out_en_n(out_en_n),
    .burst_order_sel(burst_order_sel), .sleep_request(sleep_request));
  lbsp_master lbsp_master_i (.clk_sys(clk_sys), .clock_hold_n(clock_hold_n),
    .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
    .chip_select_c_n(chip_select_c_n), .advance_or_load(advance_or_load),
    .read_not_write(read_not_write), .dq_in(dq_in));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h04c11db7 : 32'h0);
    return lfsr_q;
  endfunction
  function automatic logic [1:0] burst_low(input logic [1:0] b, k,
    input logic o);
    return o ? b ^ k : b + k;
  endfunction
  function automatic logic [17:0] merge(input logic [17:0] old, d,
    input logic [1:0] bw);
    return {bw[1] ? old[17:9] : d[17:9], bw[0] ? old[8:0] : d[8:0]};
  endfunction
  task automatic cmp(input logic [18:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic look();
    cmp({dq_oe, e_oe ? dq_out : 18'h0}, {e_oe, e_dat});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One command per cycle; the previous cycle's answer is checked first
  task automatic op(input logic ld, rw, input logic [20:0] a,
    input logic [1:0] bw, input logic [2:0] sel, input logic [17:0] d);
    @(negedge clk_sys);
    if (chk) look();
    clock_hold_n = 1'b0;
    advance_or_load = !ld;
    read_not_write = rw;
    addr = a;
    byte_write_n = bw;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = sel;
    if (pw) mem[pa] = merge(mem[pa], pd, pbw);
    pw = 1'b0;
    if (ld) begin
      live_m = (sel === 3'b010);
      wr_m = !rw;
      cur_m = a;
      base_m = a[1:0];
      k_m = 2'h0;
    end else begin
      k_m = k_m + 2'h1;
      cur_m[1:0] = burst_low(base_m, k_m,
        burst_order_sel);
    end
    if (live_m && wr_m) begin
      pw = 1'b1;
      pa = cur_m;
      pbw = bw;
      pd = d;
      lbsp_master_i.wq.push_back(d);
    end
    e_oe = live_m && !wr_m && !out_en_n;
    e_dat = e_oe ? mem[cur_m] : 18'h0;
    chk = 1'b1;
  endtask
  // Held cycles with address, direction, advance and byte enables scrambled
  task automatic hold(input int n);
    logic [31:0] h;
    repeat (n) begin
      @(negedge clk_sys);
      look();
      h = rnd();
      clock_hold_n = 1'b1;
      addr = h[20:0];
      read_not_write = h[21];
      advance_or_load = h[22];
      byte_write_n = h[24:23];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 5000);
    err_total++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    clock_hold_n = 1'b1;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'b101;
    advance_or_load = 1'b0;
    read_not_write = 1'b1;
    addr = 21'h000000;
    byte_write_n = 2'h3;
    out_en_n = 1'b0;
    burst_order_sel = 1'b1;
    sleep_request = 1'b0;
    repeat (20) @(negedge clk_sys);
    cmp({dq_oe, dq_out}, 19'h0);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int o = 0; o < 2; o++) begin
      burst_order_sel = !o[0];
      r = rnd();
      blk[o] = r[20:0];
      for (int k = 0; k < 9; k++) begin
        r = rnd();
        if (k == 0 || k == 4) op(1'b1, k == 4, blk[o], 2'h0, 3'b010, r[17:0]);
        else op(1'b0, r[19], r[20:0], 2'h0, r[23:21],
          r[17:0]);
      end
      $display("burst test order %0d done", o);
    end
    for (int b = 0; b < 4; b++) begin
      r = rnd();
      op(1'b1, 1'b0, blk[0], b[1:0], 3'b010, r[17:0]);
      op(1'b1, 1'b1, blk[0], 2'h0, 3'b010, 18'h0);
    end
    $display("lane test done");
    for (int s = 0; s < 3; s++) begin
      op(1'b1, 1'b1, blk[0], 2'h0, 3'b010 ^ (3'b001 << s), 18'h0);
      op(1'b0, 1'b1, blk[0], 2'h0, 3'b010, 18'h0);
    end
    $display("deselect test done");
    repeat (60) begin
      r = rnd();
      op(r[31:30] != 2'h0, r[29], {blk[r[28]][20:2], r[27:26]}, r[25:24],
        r[23:20] == 4'h0 ? r[2:0] : 3'b010, r[17:0]);
    end
    $display("random mix done");
    op(1'b1, 1'b1, blk[1], 2'h0, 3'b010, 18'h0);
    hold(3);
    op(1'b0, 1'b0, 21'h000000, 2'h0, 3'b101, 18'h0);
    op(1'b1, 1'b0, blk[1], 2'h0, 3'b010, 18'h2aaaa);
    hold(2);
    op(1'b1, 1'b1, blk[1], 2'h0, 3'b010, 18'h0);
    hold(1);
    #3 out_en_n = 1'b1;
    #1 cmp({18'h0, dq_oe}, 19'h0);
    out_en_n = 1'b0;
    #1 cmp({18'h0, dq_oe}, 19'h1);
    sleep_request = 1'b1;
    #1 cmp({18'h0, dq_oe}, 19'h0);
    repeat (4) @(negedge clk_sys);
    sleep_request = 1'b0;
    hold(3);
    op(1'b0, 1'b1, blk[1], 2'h0, 3'b010, 18'h0);
    op(1'b1, 1'b1, blk[0], 2'h0, 3'b101, 18'h0);
    op(1'b1, 1'b1, blk[0], 2'h0, 3'b101, 18'h0);
    hold(1);
    $display("hold and enable test done");
    stop_test();
  end
endmodule // late_write_burst_sram_port_test
